// File: verif/spcw_core_model.sv
// spcw_core_model: port core and remote station as seen by the control word.
// assumes it shares clk with spcw_top and drives just after rising edges.
`timescale 1ns/1ps
module spcw_core_model
	import spcw_pkg::*;
(
	input  wire logic                    clk,
	input  wire logic                    receiver_run,
	output logic      [5:0]              flags,
	output logic                         idle_detected,
	output logic                         addr_frame_valid,
	output logic                         addr_match,
	output logic                         break_sent,
	output logic      [SPCW_FRAME_W-1:0] tx_word,
	output logic                         tx_load,
	output logic      [SPCW_FRAME_W-1:0] rx_word,
	output logic                         rx_valid
);
	// quiet core at start
	initial begin
		flags = 6'h00;
		{idle_detected, addr_frame_valid, addr_match, break_sent} = 4'h0;
		{tx_load, rx_valid, tx_word, rx_word} = 20'h00000;
	end
	// level flags move only after an edge, as the core's would
	task automatic set_flag(input int k, input logic v);
		@(posedge clk);
		flags[k] <= v;
	endtask
	// one-cycle event: 0 idle, 1 address miss, 2 address hit, 3 break out,
	// 4 transmit load, 5 received frame; stale data shows its inverse
	task automatic pulse(input int k, input logic [SPCW_FRAME_W-1:0] w);
		@(posedge clk);
		tx_word <= w;
		rx_word <= w;
		addr_match <= (k == 2);
		// line events reach the control word even with the receiver off
		idle_detected <= (k == 0);
		addr_frame_valid <= (k == 1 || k == 2);
		break_sent <= (k == 3);
		tx_load <= (k == 4);
		rx_valid <= (k == 5) && receiver_run;
		@(posedge clk);
		{idle_detected, addr_frame_valid, break_sent, tx_load, rx_valid} <= 5'h00;
		tx_word <= ~w;
		rx_word <= ~w;
		addr_match <= (k != 2);
	endtask
endmodule

// File: verif/tb.sv
// tb: self-checking bench for the serial port control word block.
// assumes spcw_core_model stands in for the port core.
`timescale 1ns/1ps
module tb
	import spcw_pkg::*;
;
	logic        clk, reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, irq;
	logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_frame_valid;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic [5:0]  flags;
	logic        idle_detected, addr_frame_valid, addr_match, break_sent, tx_load;
	logic [8:0]  tx_word, rx_word, tx_frame;
	logic        port_on, nine_bit_word, parity_on, odd_parity_select, wake_select;
	logic        transmitter_run, receiver_run, receiver_mute, break_send_request;
	logic        rx_valid, rx_parity_bad;
	int          err_count, tests_run;

	spcw_top u_spcw_top (
		.clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.parity_error_flag(flags[0]), .tx_buffer_empty_flag(flags[1]),
		.tx_finished_flag(flags[2]), .rx_buffer_full_flag(flags[3]),
		.overrun_flag(flags[4]), .idle_line_flag(flags[5]),
		.idle_detected, .addr_frame_valid, .addr_match, .break_sent, .tx_word, .tx_load,
		.rx_word, .rx_valid, .port_on, .nine_bit_word, .parity_on, .odd_parity_select,
		.wake_select, .transmitter_run, .receiver_run, .receiver_mute,
		.break_send_request, .tx_frame, .tx_frame_valid, .rx_parity_bad, .irq
	);
	spcw_core_model u_spcw_core_model (
		.clk, .receiver_run, .flags, .idle_detected, .addr_frame_valid, .addr_match,
		.break_sent, .tx_word, .tx_load, .rx_word, .rx_valid
	);

	// 40 MHz
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// the whole run needs well under a thousand cycles
	initial begin
		#(25 * 20000);
		err_count++;
		end_sim();
	end

	task automatic end_sim();
		if (err_count == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", n, e, g);
			err_count++;
		end
	endtask
	// ready is combinational and stable mid-cycle, so sample it at the falling edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic aw_t, w_t, b_t;
		b_t = 1'b0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!b_t) begin
			@(negedge clk);
			aw_t = s_axi_awvalid && s_axi_awready;
			w_t = s_axi_wvalid && s_axi_wready;
			b_t = s_axi_bvalid;
			rsp = s_axi_bresp;
			@(posedge clk);
			if (aw_t) s_axi_awvalid <= 1'b0;
			if (w_t) s_axi_wvalid <= 1'b0;
			if (b_t) s_axi_bready <= 1'b0;
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
		logic ar_t, r_t;
		r_t = 1'b0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!r_t) begin
			@(negedge clk);
			ar_t = s_axi_arvalid && s_axi_arready;
			r_t = s_axi_rvalid;
			rd = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge clk);
			if (ar_t) s_axi_arvalid <= 1'b0;
			if (r_t) s_axi_rready <= 1'b0;
		end
		chk(n, e, rd);
	endtask
	task automatic wc(input logic [31:0] d);
		wr(SPCW_OFS_CTRL, d, SPCW_STRB_FULL);
		chk("ctrl bresp", SPCW_RESP_OKAY, rsp);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic t_regs();
		rc(SPCW_OFS_CTRL, 32'h0000_0000, "ctrl reset");
		chk("ctrl rresp", SPCW_RESP_OKAY, rsp);
		rc(SPCW_OFS_MASK, 32'h0000_001F, "mask reset");
		rc(8'h10, 32'h0000_0000, "unmapped read");
		chk("unmapped rresp", SPCW_RESP_SLVERR, rsp);
		wc(32'h0000_3FFC);
		rc(SPCW_OFS_CTRL, 32'h0000_3FFC, "ctrl readback");
		chk("cfg outs", 7'h7F, {port_on, nine_bit_word, parity_on, odd_parity_select,
			wake_select, transmitter_run, receiver_run});
		wc(32'h0000_1FFC);
		chk("runs port off", 2'h0, {transmitter_run, receiver_run});
		wr(SPCW_OFS_CTRL, 32'h0000_0000, 4'h3);
		chk("partial bresp", SPCW_RESP_SLVERR, rsp);
		wr(8'h10, 32'h0000_0000, SPCW_STRB_FULL);
		chk("unmapped bresp", SPCW_RESP_SLVERR, rsp);
		rc(SPCW_OFS_CTRL, 32'h0000_1FFC, "partial kept");
		wc(32'h0000_2008);
		chk("tx run only", 2'h2, {transmitter_run, receiver_run});
	endtask
	// each flag alone: disabled, enabled, masked, cleared
	task automatic t_irq();
		int cb[6] = '{8, 7, 6, 5, 5, 4};
		int sb[6] = '{0, 1, 2, 3, 3, 4};
		for (int k = 0; k < 6; k++) begin
			wc(32'h0000_0000);
			u_spcw_core_model.set_flag(k, 1'b1);
			settle(4);
			chk("irq disabled", 1'b0, irq);
			wc(32'h1 << cb[k]);
			settle(4);
			chk("irq enabled", 1'b1, irq);
			rc(SPCW_OFS_STAT, 32'h1 << sb[k], "stat bit");
			wr(SPCW_OFS_MASK, 32'h1F ^ (32'h1 << sb[k]), SPCW_STRB_FULL);
			settle(3);
			chk("irq masked", 1'b0, irq);
			u_spcw_core_model.set_flag(k, 1'b0);
			wr(SPCW_OFS_MASK, 32'h0000_001F, SPCW_STRB_FULL);
			wr(SPCW_OFS_STAT, 32'h1 << sb[k], SPCW_STRB_FULL);
			settle(3);
			chk("irq cleared", 1'b0, irq);
		end
	endtask
	task automatic t_mute_break();
		wc(32'h0000_2006);
		chk("mute sw set", 1'b1, receiver_mute);
		u_spcw_core_model.pulse(0, 9'h000);
		settle(2);
		rc(SPCW_OFS_CTRL, 32'h0000_2004, "idle wake");
		wc(32'h0000_2806);
		u_spcw_core_model.pulse(0, 9'h000);
		settle(2);
		chk("idle ignored", 1'b1, receiver_mute);
		u_spcw_core_model.pulse(2, 9'h000);
		settle(2);
		chk("addr hit", 1'b0, receiver_mute);
		u_spcw_core_model.pulse(1, 9'h000);
		settle(2);
		chk("addr miss", 1'b1, receiver_mute);
		wc(32'h0000_2802);
		u_spcw_core_model.pulse(2, 9'h000);
		settle(2);
		chk("rx off keeps mute", 1'b1, receiver_mute);
		wc(32'h0000_2804);
		chk("mute sw clear", 1'b0, receiver_mute);
		wc(32'h0000_2009);
		settle(3);
		chk("break held", 1'b1, break_send_request);
		u_spcw_core_model.pulse(3, 9'h000);
		settle(2);
		rc(SPCW_OFS_CTRL, 32'h0000_2008, "break done");
	endtask
	// both word lengths, both parities; good and damaged received frames
	task automatic t_parity();
		logic [8:0] w, f;
		logic       p;
		for (int m = 0; m < 4; m++) begin
			wc(32'h0000_240C | (32'(m[1]) << 12) | (32'(m[0]) << 9));
			w = 9'h1A5;
			p = (m[1] ? ^w[7:0] : ^w[6:0]) ^ m[0];
			f = m[1] ? {p, w[7:0]} : {1'b0, p, w[6:0]};
			u_spcw_core_model.pulse(4, w);
			settle(0);
			chk("tx frame", {1'b1, f}, {tx_frame_valid, tx_frame});
			u_spcw_core_model.pulse(5, f);
			settle(0);
			chk("rx good", 1'b0, rx_parity_bad);
			u_spcw_core_model.pulse(5, f ^ (m[1] ? 9'h100 : 9'h080));
			settle(0);
			chk("rx bad", 1'b1, rx_parity_bad);
		end
	endtask

	initial begin
		err_count = 0;
		tests_run = 0;
		reset_n = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_regs();
		t_irq();
		t_mute_break();
		t_parity();
		end_sim();
	end
endmodule

// File: verilog/spcw_parity_unit.sv
// spcw_parity_unit: parity insertion on transmit words, parity check on
// received frames.
// assumes tx_load and rx_valid are one-cycle pulses on clk.
`timescale 1ns/1ps
module spcw_parity_unit
	import spcw_pkg::*;
(
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	input  wire logic                    nine_bit_word,
	input  wire logic                    parity_on,
	input  wire logic                    odd_parity_select,
	input  wire logic [SPCW_FRAME_W-1:0] tx_word,
	input  wire logic                    tx_load,
	input  wire logic [SPCW_FRAME_W-1:0] rx_word,
	input  wire logic                    rx_valid,
	output logic      [SPCW_FRAME_W-1:0] tx_frame,
	output logic                         tx_frame_valid,
	output logic                         rx_parity_bad
);

	logic [SPCW_FRAME_W-1:0] low_mask;
	logic [SPCW_FRAME_W-1:0] full_mask;
	logic [SPCW_FRAME_W-1:0] tx_word_cut;
	logic                    par_bit;
	logic                    rx_sum;

	// parity covers the bits under the msb; the msb carries it
	assign low_mask    = nine_bit_word ? SPCW_LOW9 : SPCW_LOW8;
	assign full_mask   = nine_bit_word ? SPCW_FULL9 : SPCW_FULL8;
	assign tx_word_cut = tx_word & full_mask;
	assign par_bit     = (^(tx_word & low_mask)) ^ odd_parity_select;
	assign rx_sum      = ^(rx_word & full_mask);

	// transmit word, msb replaced by parity when enabled
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_frame       <= 9'h000;
			tx_frame_valid <= 1'b0;
		end else begin
			tx_frame_valid <= tx_load;
			if (tx_load) begin
				tx_frame <= tx_word_cut;
				if (parity_on && nine_bit_word)
					tx_frame[SPCW_MSB9] <= par_bit;
				else if (parity_on)
					tx_frame[SPCW_MSB8] <= par_bit;
			end
		end
	end

	// received frame check; even parity wants an even count of ones
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			rx_parity_bad <= 1'b0;
		else
			rx_parity_bad <= rx_valid && parity_on && (rx_sum != odd_parity_select);
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_msb_parity;
		tx_load && parity_on |=>
			(^(tx_frame & full_mask)) == $past(odd_parity_select);
	endproperty
	a_msb_parity: assert property (p_msb_parity) else $error("tx parity wrong");

	property p_rx_check;
		rx_valid && !parity_on |=> !rx_parity_bad;
	endproperty
	a_rx_check: assert property (p_rx_check) else $error("parity flagged while off");

endmodule

// File: verilog/spcw_pkg.sv
// spcw_pkg: register map, field positions and reset values of the serial
// port control word block.
// assumes a 32-bit AXI4-Lite register bus with byte addresses.
package spcw_pkg;

	// register byte offsets
	localparam logic [7:0] SPCW_OFS_CTRL = 8'h0C;
	localparam logic [7:0] SPCW_OFS_STAT = 8'h20;
	localparam logic [7:0] SPCW_OFS_MASK = 8'h24;
	localparam int         SPCW_ADDR_W   = 8;

	// control word field positions
	localparam int SPCW_BIT_BREAK = 0;
	localparam int SPCW_BIT_MUTE  = 1;
	localparam int SPCW_BIT_RXON  = 2;
	localparam int SPCW_BIT_TXON  = 3;
	localparam int SPCW_BIT_IDLIE = 4;
	localparam int SPCW_BIT_RXFIE = 5;
	localparam int SPCW_BIT_TXDIE = 6;
	localparam int SPCW_BIT_TXEIE = 7;
	localparam int SPCW_BIT_PARIE = 8;
	localparam int SPCW_BIT_ODD   = 9;
	localparam int SPCW_BIT_PARON = 10;
	localparam int SPCW_BIT_WAKE  = 11;
	localparam int SPCW_BIT_NINE  = 12;
	localparam int SPCW_BIT_PORT  = 13;
	localparam int SPCW_CTRL_W    = 14;

	// interrupt sources, same layout in status and mask
	localparam int SPCW_SRC_PAR  = 0;
	localparam int SPCW_SRC_TXE  = 1;
	localparam int SPCW_SRC_TXD  = 2;
	localparam int SPCW_SRC_RXF  = 3;
	localparam int SPCW_SRC_IDLE = 4;
	localparam int SPCW_NSRC     = 5;

	// reset values
	localparam logic [SPCW_CTRL_W-1:2] SPCW_CFG_RESET  = 12'h000;
	localparam logic [SPCW_NSRC-1:0]   SPCW_MASK_RESET = 5'h1F;
	localparam logic [SPCW_NSRC-1:0]   SPCW_STAT_RESET = 5'h00;

	// bus encodings
	localparam logic [3:0] SPCW_STRB_FULL   = 4'hF;
	localparam logic [1:0] SPCW_RESP_OKAY   = 2'h0;
	localparam logic [1:0] SPCW_RESP_SLVERR = 2'h2;

	// data frame
	localparam int         SPCW_FRAME_W  = 9;
	localparam logic [8:0] SPCW_LOW8     = 9'h07F;
	localparam logic [8:0] SPCW_LOW9     = 9'h0FF;
	localparam logic [8:0] SPCW_FULL8    = 9'h0FF;
	localparam logic [8:0] SPCW_FULL9    = 9'h1FF;
	localparam int         SPCW_MSB8     = 7;
	localparam int         SPCW_MSB9     = 8;

endpackage

// File: verilog/spcw_top.sv
// spcw_top: control word of the serial port, interrupt status and mask,
// AXI4-Lite register slave, mute and break control.
// assumes the port core runs on clk and feeds flags and events unsynchronised.
//
// Notes on behaviour
// - parity bit generated and checked when on; odd select picks odd.
// - parity error flag raises interrupt when its enable is set.
// - transmit buffer empty flag raises interrupt when enabled.
// - transmission complete flag raises interrupt when enabled.
// - receive full or overrun raises interrupt when enabled.
// - idle line flag raises interrupt when enabled.
// - transmitter runs only while transmitter-on is set.
// - receiver runs only while receiver-on is set.
// - wake select picks idle-frame or address-match wake from mute.
// - software sets or clears mute; bit reads one while muted.
// - idle frame clears mute when idle wake is selected.
// - address match clears mute, mismatch sets it, under address wake.
// - software requests break; hardware clears it once break is sent.
// - parity replaces the msb of the transmitted word.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module spcw_top
	import spcw_pkg::*;
(
	input  wire logic                    clk,
	input  wire logic                    reset_n,
	// register bus
	input  wire logic [SPCW_ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic      [1:0]              s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [SPCW_ADDR_W-1:0]  s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic      [31:0]             s_axi_rdata,
	output logic      [1:0]              s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	// flags and events from the port core
	input  wire logic                    parity_error_flag,
	input  wire logic                    tx_buffer_empty_flag,
	input  wire logic                    tx_finished_flag,
	input  wire logic                    rx_buffer_full_flag,
	input  wire logic                    overrun_flag,
	input  wire logic                    idle_line_flag,
	input  wire logic                    idle_detected,
	input  wire logic                    addr_frame_valid,
	input  wire logic                    addr_match,
	input  wire logic                    break_sent,
	input  wire logic [SPCW_FRAME_W-1:0] tx_word,
	input  wire logic                    tx_load,
	input  wire logic [SPCW_FRAME_W-1:0] rx_word,
	input  wire logic                    rx_valid,
	// controls towards the port core
	output logic                         port_on,
	output logic                         nine_bit_word,
	output logic                         parity_on,
	output logic                         odd_parity_select,
	output logic                         wake_select,
	output logic                         transmitter_run,
	output logic                         receiver_run,
	output logic                         receiver_mute,
	output logic                         break_send_request,
	output logic      [SPCW_FRAME_W-1:0] tx_frame,
	output logic                         tx_frame_valid,
	output logic                         rx_parity_bad,
	output logic                         irq
);

	logic [1:0]              rst_sync_reg;
	logic                    rst_n;
	logic                    aw_have_reg;
	logic [SPCW_ADDR_W-1:0]  aw_addr_reg;
	logic                    w_have_reg;
	logic [31:0]             w_data_reg;
	logic [3:0]              w_strb_reg;
	logic                    bvalid_reg;
	logic [1:0]              bresp_reg;
	logic                    rvalid_reg;
	logic [31:0]             rdata_reg;
	logic [1:0]              rresp_reg;
	logic                    do_write;
	logic                    wr_mapped;
	logic                    wr_ok;
	logic                    ctrl_wr;
	logic                    stat_wr;
	logic                    mask_wr;
	logic                    rd_take;
	logic                    rd_mapped;
	logic [31:0]             rd_word;
	logic [SPCW_CTRL_W-1:2]  cfg_reg;
	logic                    mute_reg;
	logic                    break_reg;
	logic [SPCW_CTRL_W-1:0]  ctrl_word;
	logic [SPCW_NSRC-1:0]    stat_reg;
	logic [SPCW_NSRC-1:0]    mask_reg;
	logic [SPCW_NSRC-1:0]    irq_cond;
	logic                    irq_reg;
	logic                    hw_mute_set;
	logic                    hw_mute_clr;

	// reset release through two flops; assertion stays asynchronous
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			rst_sync_reg <= 2'b00;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	assign rst_n = rst_sync_reg[1];

	// write channels taken independently, in either order
	assign s_axi_awready = !aw_have_reg && !bvalid_reg;
	assign s_axi_wready  = !w_have_reg && !bvalid_reg;
	assign do_write      = aw_have_reg && w_have_reg && !bvalid_reg;

	// write address holding
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_have_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have_reg <= 1'b1;
			aw_addr_reg <= s_axi_awaddr;
		end else if (do_write) begin
			aw_have_reg <= 1'b0;
		end
	end

	// write data holding
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			w_have_reg <= 1'b0;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have_reg <= 1'b1;
			w_data_reg <= s_axi_wdata;
			w_strb_reg <= s_axi_wstrb;
		end else if (do_write) begin
			w_have_reg <= 1'b0;
		end
	end

	// decode; byte or halfword writes are refused whole
	assign wr_mapped = (aw_addr_reg == SPCW_OFS_CTRL) || (aw_addr_reg == SPCW_OFS_STAT)
		|| (aw_addr_reg == SPCW_OFS_MASK);
	assign wr_ok     = do_write && wr_mapped && (w_strb_reg == SPCW_STRB_FULL);
	assign ctrl_wr   = wr_ok && (aw_addr_reg == SPCW_OFS_CTRL);
	assign stat_wr   = wr_ok && (aw_addr_reg == SPCW_OFS_STAT);
	assign mask_wr   = wr_ok && (aw_addr_reg == SPCW_OFS_MASK);

	// write response
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= SPCW_RESP_OKAY;
		end else if (do_write) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= wr_ok ? SPCW_RESP_OKAY : SPCW_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp  = bresp_reg;

	// read mux; upper control bits always read zero
	assign ctrl_word = {cfg_reg, mute_reg, break_reg};
	assign rd_take   = s_axi_arvalid && s_axi_arready;
	assign rd_mapped = (s_axi_araddr == SPCW_OFS_CTRL) || (s_axi_araddr == SPCW_OFS_STAT)
		|| (s_axi_araddr == SPCW_OFS_MASK);
	always_comb begin
		rd_word = 32'h0000_0000;
		if (s_axi_araddr == SPCW_OFS_CTRL)
			rd_word[SPCW_CTRL_W-1:0] = ctrl_word;
		else if (s_axi_araddr == SPCW_OFS_STAT)
			rd_word[SPCW_NSRC-1:0] = stat_reg;
		else if (s_axi_araddr == SPCW_OFS_MASK)
			rd_word[SPCW_NSRC-1:0] = mask_reg;
	end

	// read channel, one read in flight
	assign s_axi_arready = !rvalid_reg;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h0000_0000;
			rresp_reg  <= SPCW_RESP_OKAY;
		end else if (rd_take) begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= rd_word;
			rresp_reg  <= rd_mapped ? SPCW_RESP_OKAY : SPCW_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata  = rdata_reg;
	assign s_axi_rresp  = rresp_reg;

	// configuration fields; write bits above the word are dropped
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			cfg_reg <= SPCW_CFG_RESET;
		else if (ctrl_wr)
			cfg_reg <= w_data_reg[SPCW_CTRL_W-1:2];
	end

	assign port_on           = cfg_reg[SPCW_BIT_PORT];
	assign nine_bit_word     = cfg_reg[SPCW_BIT_NINE];
	assign parity_on         = cfg_reg[SPCW_BIT_PARON];
	assign odd_parity_select = cfg_reg[SPCW_BIT_ODD];
	assign wake_select       = cfg_reg[SPCW_BIT_WAKE];
	// whole-port enable overrides the per-direction enables
	assign transmitter_run   = port_on && cfg_reg[SPCW_BIT_TXON];
	assign receiver_run      = port_on && cfg_reg[SPCW_BIT_RXON];

	// hardware mute moves only while the receiver runs
	assign hw_mute_set = receiver_run && wake_select && addr_frame_valid
		&& !addr_match;
	assign hw_mute_clr = receiver_run && ((!wake_select && idle_detected)
		|| (wake_select && addr_frame_valid && addr_match));

	// mute: hardware set beats a software clear, software set beats hardware clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			mute_reg <= 1'b0;
		else if (hw_mute_set)
			mute_reg <= 1'b1;
		else if (ctrl_wr)
			mute_reg <= w_data_reg[SPCW_BIT_MUTE];
		else if (hw_mute_clr)
			mute_reg <= 1'b0;
	end
	assign receiver_mute = mute_reg;

	// break request; a fresh software request wins over completion
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			break_reg <= 1'b0;
		else if (ctrl_wr)
			break_reg <= w_data_reg[SPCW_BIT_BREAK];
		else if (break_sent)
			break_reg <= 1'b0;
	end
	assign break_send_request = break_reg;

	// enabled interrupt conditions
	assign irq_cond[SPCW_SRC_PAR]  = parity_error_flag && cfg_reg[SPCW_BIT_PARIE];
	assign irq_cond[SPCW_SRC_TXE]  = tx_buffer_empty_flag && cfg_reg[SPCW_BIT_TXEIE];
	assign irq_cond[SPCW_SRC_TXD]  = tx_finished_flag && cfg_reg[SPCW_BIT_TXDIE];
	assign irq_cond[SPCW_SRC_RXF]  = (rx_buffer_full_flag || overrun_flag)
		&& cfg_reg[SPCW_BIT_RXFIE];
	assign irq_cond[SPCW_SRC_IDLE] = idle_line_flag && cfg_reg[SPCW_BIT_IDLIE];

	// sticky status, write one to clear; a live condition re-sets at once
	genvar gi;
	generate
		for (gi = 0; gi < SPCW_NSRC; gi++) begin : g_stat
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n)
					stat_reg[gi] <= SPCW_STAT_RESET[gi];
				else if (irq_cond[gi])
					stat_reg[gi] <= 1'b1;
				else if (stat_wr && w_data_reg[gi])
					stat_reg[gi] <= 1'b0;
			end
		end
	endgenerate

	// mask resets open so the control word enables alone suffice
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			mask_reg <= SPCW_MASK_RESET;
		else if (mask_wr)
			mask_reg <= w_data_reg[SPCW_NSRC-1:0];
	end

	// registered output keeps glitches off the line
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			irq_reg <= 1'b0;
		else
			irq_reg <= |(stat_reg & mask_reg);
	end
	assign irq = irq_reg;

	// parity insertion and check on the data path
	spcw_parity_unit u_parity (
		.clk               (clk),
		.rst_n             (rst_n),
		.nine_bit_word     (nine_bit_word),
		.parity_on         (parity_on),
		.odd_parity_select (odd_parity_select),
		.tx_word           (tx_word),
		.tx_load           (tx_load),
		.rx_word           (rx_word),
		.rx_valid          (rx_valid),
		.tx_frame          (tx_frame),
		.tx_frame_valid    (tx_frame_valid),
		.rx_parity_bad     (rx_parity_bad)
	);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_part_strobe;
		do_write && (w_strb_reg != SPCW_STRB_FULL) |=>
			s_axi_bvalid && (s_axi_bresp == SPCW_RESP_SLVERR) && $stable(cfg_reg);
	endproperty
	a_part_strobe: assert property (p_part_strobe) else $error("partial write took effect");

	property p_upper_zero;
		rd_take && (s_axi_araddr == SPCW_OFS_CTRL) |=> (s_axi_rdata[31:SPCW_CTRL_W] == 18'h0);
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper control bits set");

	property p_cfg_write;
		ctrl_wr |=> (cfg_reg == $past(w_data_reg[SPCW_CTRL_W-1:2]));
	endproperty
	a_cfg_write: assert property (p_cfg_write) else $error("config not stored");

	property p_tx_off;
		!cfg_reg[SPCW_BIT_TXON] || !port_on |-> !transmitter_run;
	endproperty
	a_tx_off: assert property (p_tx_off) else $error("transmitter runs while off");

	property p_rx_off;
		$fell(port_on) |-> !receiver_run;
	endproperty
	a_rx_off: assert property (p_rx_off) else $error("receiver runs while port off");

	property p_idle_wake;
		receiver_run && !wake_select && idle_detected && !ctrl_wr |=> !receiver_mute;
	endproperty
	a_idle_wake: assert property (p_idle_wake) else $error("idle frame did not unmute");

	property p_addr_miss;
		receiver_run && wake_select && addr_frame_valid && !addr_match |=> receiver_mute;
	endproperty
	a_addr_miss: assert property (p_addr_miss) else $error("mismatch did not mute");

	property p_addr_hit;
		receiver_run && wake_select && addr_frame_valid && addr_match && !ctrl_wr
			|=> !receiver_mute;
	endproperty
	a_addr_hit: assert property (p_addr_hit) else $error("match did not unmute");

	property p_break_done;
		break_send_request && break_sent && !ctrl_wr |=> !break_send_request;
	endproperty
	a_break_done: assert property (p_break_done) else $error("break not cleared");

	property p_par_irq;
		irq_cond[SPCW_SRC_PAR] && mask_reg[SPCW_SRC_PAR] |-> ##[1:2] irq;
	endproperty
	a_par_irq: assert property (p_par_irq) else $error("parity irq missing");

	property p_rxf_irq;
		overrun_flag && cfg_reg[SPCW_BIT_RXFIE] && mask_reg[SPCW_SRC_RXF] |-> ##[1:2] irq;
	endproperty
	a_rxf_irq: assert property (p_rxf_irq) else $error("overrun irq missing");

	property p_irq_cause;
		irq |-> $past(|(stat_reg & mask_reg));
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");

endmodule
